// *** rtl/smt_top.sv ***
// split-mode timer control: registers, commands, flags and two 8-bit down counters
// assumes a single-cycle register port and a debug-halt level from the core
`timescale 1ns/10ps
module smt_top (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic CE,
    input wire logic DEBUG_HALT,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    output logic INT_REQ,
    output logic [7:0] WAVE_OUT
);

    // ==========================================
    // decode
    smt_pkg::smt_state_t q;
    smt_pkg::smt_state_t d;
    smt_pkg::smt_bus_t bus;
    logic [1:0] cmd_w;
    logic [1:0] tgt_w;
    logic cmd_wr;
    logic do_restart;
    logic do_reset;
    logic wr_low_byte_count;
    logic wr_hcnt;
    logic run;
    logic [7:0] set_v;
    logic [7:0] clr_v;

    assign bus = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};
    assign cmd_w = bus.wdata[smt_pkg::CMD_LSB +: 2];
    assign tgt_w = bus.wdata[smt_pkg::TGT_LSB +: 2];
    assign cmd_wr = bus.wr && (bus.addr == smt_pkg::ADR_CMDCLR || bus.addr == smt_pkg::ADR_CMDSET);
    // reserved codes and partial targets do nothing
    assign do_restart = cmd_wr && cmd_w == smt_pkg::CMD_RESTART && tgt_w == smt_pkg::TGT_BOTH;
    assign do_reset = cmd_wr && cmd_w == smt_pkg::CMD_RESET && tgt_w == smt_pkg::TGT_BOTH && !q.en;
    assign wr_low_byte_count = bus.wr && q.split && bus.addr == smt_pkg::ADR_LOW_BYTE_COUNT;
    assign wr_hcnt = bus.wr && q.split && bus.addr == smt_pkg::ADR_HCNT;
    assign run = q.en && q.split && (!DEBUG_HALT || q.dbg);
    assign clr_v = (bus.wr && bus.addr == smt_pkg::ADR_FLAGS) ? (bus.wdata & smt_pkg::INT_MASK) : 8'h00;

    // ==========================================
    // next state
    always_comb begin
        d = q;
        d.rdata = 8'h00;
        set_v = 8'h00;
        // counting first so a register write below overrides it
        if (do_restart) begin
            d.low_byte_count = q.lper;
            d.hcnt = q.hper;
        end else if (run) begin
            d.low_byte_count = (q.low_byte_count == 8'h00) ? q.lper : q.low_byte_count - 8'h01;
            d.hcnt = (q.hcnt == 8'h00) ? q.hper : q.hcnt - 8'h01;
            set_v[smt_pkg::BIT_LOW_UNDERFLOW] = !wr_low_byte_count && q.low_byte_count == 8'h01;
            set_v[smt_pkg::BIT_HIGH_UNDERFLOW] = !wr_hcnt && q.hcnt == 8'h01;
        end
        for (int n = 0; n < smt_pkg::NUM_CMP; n++) begin
            set_v[smt_pkg::BIT_LCMP0 + n] = q.split && q.low_byte_count == q.lcmp[n];
        end
        // set wins over a same-cycle clear
        d.flags = (q.flags & ~clr_v) | set_v;

        if (bus.rd) begin
            case (bus.addr)
                smt_pkg::ADR_ENABLE: d.rdata = {7'h00, q.en};
                smt_pkg::ADR_OUTVAL: d.rdata = q.ov;
                smt_pkg::ADR_SPLIT: d.rdata = {7'h00, q.split};
                smt_pkg::ADR_CMDCLR, smt_pkg::ADR_CMDSET: d.rdata = {6'h00, q.tgt};
                smt_pkg::ADR_INTEN: d.rdata = q.ie;
                smt_pkg::ADR_FLAGS: d.rdata = q.flags;
                smt_pkg::ADR_DBG: d.rdata = {7'h00, q.dbg};
                default: d.rdata = 8'h00;
            endcase
            // timer registers appear only in the split layout
            if (q.split) begin
                case (bus.addr)
                    smt_pkg::ADR_LOW_BYTE_COUNT: d.rdata = q.low_byte_count;
                    smt_pkg::ADR_HCNT: d.rdata = q.hcnt;
                    smt_pkg::ADR_LPER: d.rdata = q.lper;
                    smt_pkg::ADR_HPER: d.rdata = q.hper;
                    default: d.rdata = d.rdata;
                endcase
                for (int n = 0; n < smt_pkg::NUM_CMP; n++) begin
                    if (bus.addr == smt_pkg::ADR_LCMP0 + 8'(n * 2)) begin
                        d.rdata = q.lcmp[n];
                    end
                end
            end
        end

        if (bus.wr) begin
            case (bus.addr)
                smt_pkg::ADR_ENABLE: d.en = bus.wdata[0];
                smt_pkg::ADR_OUTVAL: d.ov = bus.wdata & smt_pkg::OV_MASK;
                smt_pkg::ADR_SPLIT: d.split = bus.wdata[0];
                smt_pkg::ADR_CMDCLR: d.tgt = q.tgt & ~tgt_w;
                smt_pkg::ADR_CMDSET: d.tgt = q.tgt | tgt_w;
                smt_pkg::ADR_INTEN: d.ie = bus.wdata & smt_pkg::INT_MASK;
                smt_pkg::ADR_DBG: d.dbg = bus.wdata[0];
                default: d.dbg = d.dbg;
            endcase
            if (q.split) begin
                case (bus.addr)
                    smt_pkg::ADR_LOW_BYTE_COUNT: d.low_byte_count = bus.wdata;
                    smt_pkg::ADR_HCNT: d.hcnt = bus.wdata;
                    smt_pkg::ADR_LPER: d.lper = bus.wdata;
                    smt_pkg::ADR_HPER: d.hper = bus.wdata;
                    default: d.lper = d.lper;
                endcase
                for (int n = 0; n < smt_pkg::NUM_CMP; n++) begin
                    if (bus.addr == smt_pkg::ADR_LCMP0 + 8'(n * 2)) begin
                        d.lcmp[n] = bus.wdata;
                    end
                end
            end
        end

        // hard reset returns every register to its reset value
        if (do_reset) begin
            d = smt_pkg::ST_RST;
        end
        d.irq = |(d.flags & d.ie);
        // while running the pins hold; waveform shaping lives elsewhere
        d.wave = d.en ? q.wave : d.ov;
    end

    // ==========================================
    // state register
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            q <= smt_pkg::ST_RST;
        end else if (CE) begin
            q <= d;
        end
    end

    assign REG_RDATA = q.rdata;
    assign INT_REQ = q.irq;
    assign WAVE_OUT = q.wave;

    // ==========================================
    // checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    sequence s_low_byte_count_write;
        CE && wr_low_byte_count;
    endsequence

    sequence s_count_step;
        CE && run && !do_restart && !bus.wr;
    endsequence

    sequence s_flag_kept(int b);
        CE && q.flags[b] && !clr_v[b] && !do_reset;
    endsequence

    sequence s_flag_clear(int b);
        CE && clr_v[b];
    endsequence

    ov_drive_a: assert property (CE && !d.en |=> WAVE_OUT == q.ov)
        else $error("output pins do not follow value bits");
    split_count_a: assert property (s_count_step and q.low_byte_count != 8'h00 |=> q.low_byte_count == $past(q.low_byte_count) - 8'h01)
        else $error("low counter did not step down");
    layout_a: assert property (CE && REG_RD && !q.split && REG_ADDR == smt_pkg::ADR_LOW_BYTE_COUNT |=> REG_RDATA == 8'h00)
        else $error("split registers visible outside split layout");
    clr_cmd_a: assert property (CE && REG_WR && REG_ADDR == smt_pkg::ADR_CMDCLR && !do_reset
        |=> q.tgt == ($past(q.tgt) & ~$past(tgt_w)))
        else $error("clear register touched unwritten bits");
    set_cmd_a: assert property (CE && REG_WR && REG_ADDR == smt_pkg::ADR_CMDSET && !do_reset
        |=> q.tgt == ($past(q.tgt) | $past(tgt_w)))
        else $error("set register touched unwritten bits");
    cmd_read_a: assert property (CE && REG_RD && (REG_ADDR == smt_pkg::ADR_CMDSET || REG_ADDR == smt_pkg::ADR_CMDCLR)
        |=> REG_RDATA[3:2] == 2'h0)
        else $error("command field read non-zero");
    restart_a: assert property (CE && do_restart |=> q.low_byte_count == $past(q.lper) && q.hcnt == $past(q.hper))
        else $error("restart did not reload both counters");
    hard_reset_a: assert property (CE && cmd_wr && cmd_w == smt_pkg::CMD_RESET && tgt_w == smt_pkg::TGT_BOTH
        |=> (q.en || (q.split == 1'b0 && q.lper == smt_pkg::RST_PER && q.ie == 8'h00)))
        else $error("hard reset misbehaved");
    ignored_reset_a: assert property (CE && q.en && cmd_wr && cmd_w == smt_pkg::CMD_RESET |=> q.en)
        else $error("hard reset acted while enabled");
    irq_a: assert property (|(q.flags & q.ie) |-> INT_REQ)
        else $error("enabled flag gives no interrupt");
    cmp_flag_a: assert property (CE && q.split && q.low_byte_count == q.lcmp[0] && !do_reset |=> q.flags[smt_pkg::BIT_LCMP0])
        else $error("compare match did not set flag");
    cmp_hold_a: assert property (s_flag_kept(smt_pkg::BIT_LCMP0) |=> q.flags[smt_pkg::BIT_LCMP0])
        else $error("compare flag lost without clear");
    high_underflow_a: assert property (s_count_step and q.hcnt == 8'h01 |=> q.hcnt == 8'h00 ##0 q.flags[smt_pkg::BIT_HIGH_UNDERFLOW])
        else $error("high underflow not flagged");
    high_underflow_hold_a: assert property (s_flag_kept(smt_pkg::BIT_HIGH_UNDERFLOW) |=> q.flags[smt_pkg::BIT_HIGH_UNDERFLOW])
        else $error("high underflow lost without clear");
    low_underflow_a: assert property (s_count_step and q.low_byte_count == 8'h01 |=> q.flags[smt_pkg::BIT_LOW_UNDERFLOW])
        else $error("low underflow not flagged");
    halt_a: assert property (CE && DEBUG_HALT && !q.dbg && !bus.wr |=> $stable(q.low_byte_count) && $stable(q.hcnt))
        else $error("counter moved during break");
    dbg_run_a: assert property (s_count_step and DEBUG_HALT && q.dbg && q.low_byte_count != 8'h00
        |=> q.low_byte_count != $past(q.low_byte_count))
        else $error("counter stopped with debug run set");
    prio_a: assert property (s_low_byte_count_write |=> q.low_byte_count == $past(REG_WDATA))
        else $error("counter write lost to count");

    // ==========================================
    // register port
    // a read strobe leaves data for exactly one cycle, zero otherwise

    rdata_idle_a: assert property (CE && !REG_RD |=> REG_RDATA == 8'h00)
        else $error("read data not zero outside read answer");

    low_byte_count_read_a: assert property (CE && REG_RD && q.split && REG_ADDR == smt_pkg::ADR_LOW_BYTE_COUNT
        |=> REG_RDATA == $past(q.low_byte_count))
        else $error("low count read back wrong");

    split_read_a: assert property (CE && REG_RD && REG_ADDR == smt_pkg::ADR_SPLIT
        |=> REG_RDATA == {7'h00, $past(q.split)})
        else $error("split select read back wrong");

    split_write_a: assert property (CE && REG_WR && REG_ADDR == smt_pkg::ADR_SPLIT
        |=> q.split == $past(REG_WDATA[0]))
        else $error("split select write lost");

    per_layout_a: assert property (CE && REG_RD && !q.split && REG_ADDR == smt_pkg::ADR_LPER
        |=> REG_RDATA == 8'h00)
        else $error("period visible outside split layout");

    lper_write_a: assert property (CE && REG_WR && q.split && REG_ADDR == smt_pkg::ADR_LPER
        |=> q.lper == $past(REG_WDATA))
        else $error("low period write lost");

    hper_write_a: assert property (CE && REG_WR && q.split && REG_ADDR == smt_pkg::ADR_HPER
        |=> q.hper == $past(REG_WDATA))
        else $error("high period write lost");

    lcmp_write_a: assert property (CE && REG_WR && q.split && REG_ADDR == smt_pkg::ADR_LCMP0
        |=> q.lcmp[0] == $past(REG_WDATA))
        else $error("compare value write lost");

    tgt_read_a: assert property (CE && REG_RD && REG_ADDR == smt_pkg::ADR_CMDSET
        |=> REG_RDATA == {6'h00, $past(q.tgt)})
        else $error("target field read back wrong");

    dbg_write_a: assert property (CE && REG_WR && REG_ADDR == smt_pkg::ADR_DBG
        |=> q.dbg == $past(REG_WDATA[0]))
        else $error("debug run write lost");

    // ==========================================
    // counting and commands
    // counters only count in split layout, so a plain layout keeps them still except on restart or hard reset

    no_split_run_a: assert property (CE && !q.split && !bus.wr |=> $stable(q.low_byte_count) && $stable(q.hcnt))
        else $error("counter moved outside split layout");

    hcnt_step_a: assert property (s_count_step and q.hcnt != 8'h00 |=> q.hcnt == $past(q.hcnt) - 8'h01)
        else $error("high counter did not step down");

    reload_a: assert property (s_count_step and q.low_byte_count == 8'h00 |=> q.low_byte_count == $past(q.lper))
        else $error("low counter did not reload");

    restart_none_a: assert property (CE && cmd_wr && tgt_w == smt_pkg::TGT_NONE && !run
        |=> $stable(q.low_byte_count) && $stable(q.hcnt))
        else $error("command acted with no target");

    reserved_cmd_a: assert property (CE && cmd_wr && cmd_w != smt_pkg::CMD_RESTART && cmd_w != smt_pkg::CMD_RESET
        && !run |=> $stable(q.low_byte_count) && $stable(q.hcnt) && $stable(q.split))
        else $error("reserved command had an effect");

    reset_regs_a: assert property (CE && do_reset
        |=> !q.split && q.flags == smt_pkg::RST_REG && q.ie == smt_pkg::RST_REG)
        else $error("hard reset left registers set");

    reset_period_a: assert property (CE && do_reset
        |=> q.lper == smt_pkg::RST_PER && q.hper == smt_pkg::RST_PER)
        else $error("hard reset left periods changed");

    hprio_a: assert property (CE && wr_hcnt |=> q.hcnt == $past(REG_WDATA))
        else $error("high counter write lost to count");

    low_underflow_write_a: assert property (CE && wr_low_byte_count && q.low_byte_count == 8'h01 && !q.flags[smt_pkg::BIT_LOW_UNDERFLOW]
        |=> !q.flags[smt_pkg::BIT_LOW_UNDERFLOW])
        else $error("counter write raised underflow");

    // ==========================================
    // flags and interrupt request
    // the hard reset clears flags, so hold checks leave that cycle out

    ie_mask_a: assert property ((q.ie & ~smt_pkg::INT_MASK) == 8'h00)
        else $error("unused enable bit set");

    flag_mask_a: assert property ((q.flags & ~smt_pkg::INT_MASK) == 8'h00)
        else $error("unused flag bit set");

    irq_low_a: assert property (!(|(q.flags & q.ie)) |-> !INT_REQ)
        else $error("interrupt without enabled flag");

    cmp1_flag_a: assert property (CE && q.split && q.low_byte_count == q.lcmp[1] && !do_reset
        |=> q.flags[smt_pkg::BIT_LCMP0 + 1])
        else $error("compare one match did not set flag");

    cmp2_flag_a: assert property (CE && q.split && q.low_byte_count == q.lcmp[2] && !do_reset
        |=> q.flags[smt_pkg::BIT_LCMP0 + 2])
        else $error("compare two match did not set flag");

    cmp1_hold_a: assert property (s_flag_kept(smt_pkg::BIT_LCMP0 + 1) |=> q.flags[smt_pkg::BIT_LCMP0 + 1])
        else $error("compare one flag lost without clear");

    cmp2_hold_a: assert property (s_flag_kept(smt_pkg::BIT_LCMP0 + 2) |=> q.flags[smt_pkg::BIT_LCMP0 + 2])
        else $error("compare two flag lost without clear");

    low_underflow_hold_a: assert property (s_flag_kept(smt_pkg::BIT_LOW_UNDERFLOW) |=> q.flags[smt_pkg::BIT_LOW_UNDERFLOW])
        else $error("low underflow lost without clear");

    low_underflow_clear_a: assert property (s_flag_clear(smt_pkg::BIT_LOW_UNDERFLOW) and !(run && q.low_byte_count == 8'h01)
        |=> !q.flags[smt_pkg::BIT_LOW_UNDERFLOW])
        else $error("low underflow not cleared by write");

    set_wins_a: assert property (s_flag_clear(smt_pkg::BIT_LOW_UNDERFLOW) and run && q.low_byte_count == 8'h01
        |=> q.flags[smt_pkg::BIT_LOW_UNDERFLOW])
        else $error("clear beat same-cycle underflow");

    low_underflow_quiet_a: assert property (CE && !q.flags[smt_pkg::BIT_LOW_UNDERFLOW] && !run |=> !q.flags[smt_pkg::BIT_LOW_UNDERFLOW])
        else $error("low underflow without count");

    high_underflow_quiet_a: assert property (CE && !q.flags[smt_pkg::BIT_HIGH_UNDERFLOW] && !run |=> !q.flags[smt_pkg::BIT_HIGH_UNDERFLOW])
        else $error("high underflow without count");

    // ==========================================
    // output pins
    // pins freeze while running; only the disabled state lets value bits through

    wave_hold_a: assert property (CE && q.en && d.en |=> $stable(WAVE_OUT))
        else $error("output pins moved while enabled");

    ov_mask_a: assert property ((q.ov & ~smt_pkg::OV_MASK) == 8'h00)
        else $error("unused output value bit set");

    en_write_a: assert property (CE && REG_WR && REG_ADDR == smt_pkg::ADR_ENABLE
        |=> q.en == $past(REG_WDATA[0]))
        else $error("enable write lost");

endmodule

// *** common/smt_pkg.sv ***
// split-mode timer control: register map, field positions, reset values
// assumes an 8-bit register port with byte offsets as addresses
package smt_pkg;

    // ==========================================
    // register offsets
    localparam logic [7:0] ADR_ENABLE = 8'h00;
    localparam logic [7:0] ADR_OUTVAL = 8'h02;
    localparam logic [7:0] ADR_SPLIT = 8'h03;
    localparam logic [7:0] ADR_CMDCLR = 8'h04;
    localparam logic [7:0] ADR_CMDSET = 8'h05;
    localparam logic [7:0] ADR_INTEN = 8'h0a;
    localparam logic [7:0] ADR_FLAGS = 8'h0b;
    localparam logic [7:0] ADR_DBG = 8'h0e;
    localparam logic [7:0] ADR_LOW_BYTE_COUNT = 8'h20;
    localparam logic [7:0] ADR_HCNT = 8'h21;
    localparam logic [7:0] ADR_LPER = 8'h26;
    localparam logic [7:0] ADR_HPER = 8'h27;
    localparam logic [7:0] ADR_LCMP0 = 8'h28;
    localparam logic [7:0] ADR_LCMP_STEP = 8'h02;
    localparam int NUM_CMP = 3;

    // ==========================================
    // field positions and masks
    localparam int BIT_LOW_UNDERFLOW = 0;
    localparam int BIT_HIGH_UNDERFLOW = 1;
    localparam int BIT_LCMP0 = 4;
    localparam logic [7:0] INT_MASK = 8'h73;
    localparam logic [7:0] OV_MASK = 8'h77;
    localparam int CMD_LSB = 2;
    localparam int TGT_LSB = 0;

    // ==========================================
    // command and target codes
    localparam logic [1:0] CMD_NONE = 2'h0;
    localparam logic [1:0] CMD_RESTART = 2'h2;
    localparam logic [1:0] CMD_RESET = 2'h3;
    localparam logic [1:0] TGT_NONE = 2'h0;
    localparam logic [1:0] TGT_BOTH = 2'h3;

    // ==========================================
    // reset values
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] RST_PER = 8'hff;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } smt_bus_t;

    typedef struct packed {
        logic en;
        logic [7:0] ov;
        logic split;
        logic [1:0] tgt;
        logic [7:0] ie;
        logic [7:0] flags;
        logic dbg;
        logic [7:0] low_byte_count;
        logic [7:0] hcnt;
        logic [7:0] lper;
        logic [7:0] hper;
        logic [NUM_CMP-1:0][7:0] lcmp;
        logic [7:0] rdata;
        logic irq;
        logic [7:0] wave;
    } smt_state_t;

    localparam smt_state_t ST_RST = '{lper: RST_PER, hper: RST_PER, default: '0};

endpackage

// *** test/smt_top_tb_top.sv ***
// self-checking bench for the split-mode timer control block
// assumes smt_top and smt_pkg are compiled first; the bench drives every port itself
`timescale 1ns/10ps
module smt_top_tb_top;
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } smt_row_t;

    logic MCLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic CE = 1'b1;
    logic DEBUG_HALT = 1'b0;
    logic [7:0] REG_ADDR = 8'h00;
    logic [7:0] REG_WDATA = 8'h00;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [7:0] REG_RDATA;
    logic INT_REQ;
    logic [7:0] WAVE_OUT;
    int mismatches = 0;
    int tests_run = 0;
    logic [7:0] got;
    // low_byte_count written right after split so that count 0 versus compare 0 does not muddy the flag rows
    smt_row_t rows [12] = '{
        '{1'b0, 8'h03, 8'h00, 8'h00}, '{1'b0, 8'h26, 8'h00, 8'h00}, '{1'b0, 8'h20, 8'h00, 8'h00},
        '{1'b1, 8'h03, 8'h01, 8'h01}, '{1'b1, 8'h20, 8'h5a, 8'h5a}, '{1'b1, 8'h0b, 8'hff, 8'h00},
        '{1'b1, 8'h0a, 8'hff, 8'h73}, '{1'b1, 8'h05, 8'h07, 8'h03}, '{1'b1, 8'h04, 8'h06, 8'h01},
        '{1'b1, 8'h0e, 8'h01, 8'h01}, '{1'b1, 8'h27, 8'h03, 8'h03}, '{1'b1, 8'h07, 8'h55, 8'h00}
    };

    smt_top DUT (
        .MCLK(MCLK), .SYS_RST(SYS_RST), .CE(CE), .DEBUG_HALT(DEBUG_HALT),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .INT_REQ(INT_REQ), .WAVE_OUT(WAVE_OUT)
    );

    initial begin
        forever #2 MCLK = ~MCLK;
    end

    // ==========================================
    // bus cycles and comparisons
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge MCLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge MCLK);
        REG_WR <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge MCLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge MCLK);
        REG_RD <= 1'b0;
        #1 d = REG_RDATA;
    endtask

    task automatic check(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        check(d, e);
    endtask

    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ==========================================
    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge MCLK);
        mismatches++;
        end_sim();
    end

    // ==========================================
    // main sequence
    initial begin
        repeat (20) @(posedge MCLK);
        SYS_RST <= 1'b0;
        check(WAVE_OUT, 8'h00);
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                wr(rows[i].addr, rows[i].wdata);
            end
            rd_check(rows[i].addr, rows[i].exp);
        end
        $display("test register table done");
        wr(8'h26, 8'h03);
        wr(8'h20, 8'h02);
        wr(8'h21, 8'h02);
        wr(8'h0a, 8'h01);
        wr(8'h00, 8'h01);
        for (int n = 0; n < 20 && INT_REQ !== 1'b1; n++) @(posedge MCLK);
        check({7'h00, INT_REQ}, 8'h01);
        wr(8'h00, 8'h00);
        wr(8'h20, 8'h80);
        rd_check(8'h0b, 8'h73);
        wr(8'h0b, 8'h01);
        rd_check(8'h0b, 8'h72);
        repeat (2) @(posedge MCLK);
        check({7'h00, INT_REQ}, 8'h00);
        wr(8'h0a, 8'h02);
        repeat (2) @(posedge MCLK);
        check({7'h00, INT_REQ}, 8'h01);
        wr(8'h0a, 8'h70);
        repeat (2) @(posedge MCLK);
        check({7'h00, INT_REQ}, 8'h01);
        wr(8'h0b, 8'h72);
        rd_check(8'h0b, 8'h00);
        check({7'h00, INT_REQ}, 8'h00);
        $display("test flags and interrupt done");
        DEBUG_HALT <= 1'b1;
        wr(8'h0e, 8'h00);
        wr(8'h00, 8'h01);
        repeat (6) @(posedge MCLK);
        wr(8'h00, 8'h00);
        rd_check(8'h20, 8'h80);
        wr(8'h0e, 8'h01);
        wr(8'h00, 8'h01);
        repeat (6) @(posedge MCLK);
        // write lands at one edge, then one count step before the read is answered
        wr(8'h20, 8'h40);
        rd_check(8'h20, 8'h3f);
        wr(8'h00, 8'h00);
        rd(8'h20, got);
        check({7'h00, got !== 8'h80}, 8'h01);
        DEBUG_HALT <= 1'b0;
        $display("test debug halt done");
        wr(8'h20, 8'h10);
        wr(8'h05, 8'h08);
        rd_check(8'h20, 8'h10);
        wr(8'h05, 8'h0b);
        rd_check(8'h20, 8'h03);
        wr(8'h00, 8'h01);
        wr(8'h05, 8'h0f);
        wr(8'h00, 8'h00);
        rd_check(8'h26, 8'h03);
        wr(8'h05, 8'h0f);
        rd_check(8'h03, 8'h00);
        wr(8'h03, 8'h01);
        rd_check(8'h26, 8'hff);
        $display("test commands done");
        wr(8'h02, 8'hff);
        repeat (2) @(posedge MCLK);
        check(WAVE_OUT, 8'h77);
        wr(8'h00, 8'h01);
        wr(8'h02, 8'h00);
        repeat (2) @(posedge MCLK);
        check(WAVE_OUT, 8'h77);
        $display("test output values done");
        // second reset in mid-run must clear outputs and restore period reset values
        SYS_RST <= 1'b1;
        repeat (3) @(posedge MCLK);
        SYS_RST <= 1'b0;
        check(WAVE_OUT, 8'h00);
        wr(8'h03, 8'h01);
        rd_check(8'h26, 8'hff);
        $display("test second reset done");
        end_sim();
    end
endmodule
